//--- common/clhp_pkg.sv
// Notes on behaviour
// - Line and font bits pick glyph size, duty
// - Instruction 01xxxxxx loads pointer, selects glyph memory
// - Instruction 1xxxxxxx loads pointer, selects text memory
// - One-line text addresses run 00H to 4FH
// - Two-line text: 00H-27H and 40H-67H
// - Status read gives busy and pointer
// - Data write stores byte in selected memory
// - Pointer steps after each data write
// - Data read returns byte, parallel only
// - First read without address set is invalid
// - Cursor shift also preloads read latch
// - Pointer steps after each data read
// - Four-bit mode uses upper lines, two transfers
// - Four-bit mode sends high nibble first
// - Busy rises after second nibble only
// - Eight-bit mode moves byte in one transfer
// - Straps select parallel, two-wire or serial
// - Serial uses lines 5, 7, 6 and select
// - Serial clock idles high, data taken rising
// - Direction bit one increments, zero decrements
package clhp_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned BUSY_US = 37;
  localparam int unsigned BUSY_CYC = BUSY_US * CLK_MHZ;
  localparam logic [6:0] TXT_ONE_LAST = 7'h4F;
  localparam logic [6:0] TXT_L1_LAST = 7'h27;
  localparam logic [6:0] TXT_L2_FIRST = 7'h40;
  localparam logic [6:0] TXT_L2_LAST = 7'h67;
  localparam logic [5:0] GLY_LAST = 6'h3F;
  localparam int unsigned TXT_DEPTH = 128;
  localparam int unsigned GLY_DEPTH = 64;
  localparam int unsigned B_DDR = 7;
  localparam int unsigned B_CGR = 6;
  localparam int unsigned B_FSET = 5;
  localparam int unsigned B_SHIFT = 4;
  localparam int unsigned B_ENTRY = 2;
  localparam int unsigned B_DL = 4;
  localparam int unsigned B_N = 3;
  localparam int unsigned B_F = 2;
  localparam int unsigned B_ID = 1;
  localparam int unsigned B_RL = 2;
  localparam int unsigned B_SC = 3;
  localparam int unsigned SPI_CS = 5;
  localparam int unsigned SPI_CLK = 6;
  localparam int unsigned SPI_DAT = 7;
  localparam logic [3:0] SER_LAST = 4'h7;
  typedef enum logic [1:0] {IF_PAR = 2'h0, IF_I2C = 2'h1, IF_SPI = 2'h2} clhp_if_e;
  typedef enum logic [1:0] {DM_8 = 2'h0, DM_11 = 2'h1, DM_16 = 2'h3} clhp_duty_e;
  typedef struct packed {
    logic rs;
    logic [7:0] byte_val;
  } clhp_xfer_s;
endpackage : clhp_pkg

//--- core/clhp_port.sv
`timescale 1ns/1ps
module clhp_port
  import clhp_pkg::*;
(
  input wire logic i_ref_clk, // 250 MHz
  input wire logic i_sys_rst, // Sync reset, high
  input wire logic i_interface_strap_hi, // Strap, high selects serial
  input wire logic i_interface_strap_lo, // Strap, high selects two-wire
  input wire logic i_enable, // Parallel strobe E
  input wire logic i_register_select, // Register select pin
  input wire logic i_read_write, // High read, low write
  input wire logic [7:0] i_data, // Data lines in
  output logic [7:0] o_data, // Data lines out
  output logic [7:0] o_data_oe, // Data lines drive enable
  output logic o_busy_indicator, // Busy
  output logic [6:0] o_address_pointer, // Pointer
  output logic o_glyph_sel, // Glyph memory selected
  output logic o_two_line, // Line-count bit
  output logic [1:0] o_duty, // Duty mode
  output logic o_bus_width_bit, // High eight-bit bus
  output logic [1:0] o_if_mode // Selected interface
);
  logic [1:0] strap_m;
  logic [1:0] strap_s;
  logic [7:0] data_m;
  logic [7:0] data_s;
  logic [2:0] ctl_m;
  logic [2:0] ctl_s;
  logic en_d;
  logic sclk_d;
  always_ff @(posedge i_ref_clk)
  begin
    strap_m <= {i_interface_strap_hi, i_interface_strap_lo};
    strap_s <= strap_m;
    data_m <= i_data;
    data_s <= data_m;
    ctl_m <= {i_enable, i_register_select, i_read_write};
    ctl_s <= ctl_m;
    en_d <= ctl_s[2];
    sclk_d <= data_s[SPI_CLK];
  end

  clhp_if_e if_mode;
  always_comb
  begin
    if (strap_s[1])
      if_mode = IF_SPI;
    else if (strap_s[0])
      if_mode = IF_I2C;
    else
      if_mode = IF_PAR;
  end

  logic [7:0] txt_mem [TXT_DEPTH];
  logic [7:0] gly_mem [GLY_DEPTH];
  logic glyph_sel;
  logic [6:0] ptr;
  logic dir_inc;
  logic two_line;
  logic font_big;
  logic bw8;
  logic busy;
  logic [$clog2(BUSY_CYC+1)-1:0] busy_cnt;
  logic [7:0] rd_latch;
  logic rd_fill;
  logic nib_phase;
  logic [3:0] nib_hi;
  logic [3:0] ser_cnt;
  logic [7:0] ser_sh;
  clhp_xfer_s xfer;
  logic xfer_vld;
  logic rd_step;

  wire en_fall = en_d && !ctl_s[2];
  wire par_act = (if_mode == IF_PAR) && en_fall;
  wire spi_sel = (if_mode == IF_SPI) && !data_s[SPI_CS];
  wire sclk_rise = spi_sel && data_s[SPI_CLK] && !sclk_d;

  // Assembles a whole byte from the parallel or serial path
  always_ff @(posedge i_ref_clk)
  begin
    xfer_vld <= 1'b0;
    rd_step <= 1'b0;
    if (i_sys_rst)
    begin
      nib_phase <= 1'b0;
      nib_hi <= 4'h0;
      ser_cnt <= 4'h0;
      ser_sh <= 8'h00;
      xfer <= '0;
    end
    else
    begin
      if (par_act && !ctl_s[0])
      begin
        if (bw8)
        begin
          xfer <= '{rs: ctl_s[1], byte_val: data_s};
          xfer_vld <= 1'b1;
        end
        else if (!nib_phase)
        begin
          nib_hi <= data_s[7:4];
          nib_phase <= 1'b1;
        end
        else
        begin
          xfer <= '{rs: ctl_s[1], byte_val: {nib_hi, data_s[7:4]}};
          xfer_vld <= 1'b1;
          nib_phase <= 1'b0;
        end
      end
      else if (par_act && ctl_s[0])
      begin
        // Step only after the low nibble of a data read
        if (bw8 || nib_phase)
          rd_step <= ctl_s[1];
        nib_phase <= bw8 ? 1'b0 : !nib_phase;
      end
      if (!spi_sel)
        ser_cnt <= 4'h0;
      else if (sclk_rise)
      begin
        ser_sh <= {ser_sh[6:0], data_s[SPI_DAT]};
        ser_cnt <= (ser_cnt == SER_LAST) ? 4'h0 : ser_cnt + 4'h1;
        if (ser_cnt == SER_LAST)
        begin
          xfer <= '{rs: ctl_s[1], byte_val: {ser_sh[6:0], data_s[SPI_DAT]}};
          xfer_vld <= 1'b1;
        end
      end
    end
  end

  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic inc,
                                          input logic gly, input logic two);
    logic [6:0] r;
    r = p;
    if (gly)
      r = {1'b0, inc ? p[5:0] + 6'h01 : p[5:0] - 6'h01};
    else if (!two)
    begin
      if (inc)
        r = (p >= TXT_ONE_LAST) ? 7'h00 : p + 7'h01;
      else
        r = (p == 7'h00) ? TXT_ONE_LAST : p - 7'h01;
    end
    else if (inc)
    begin
      if (p == TXT_L1_LAST)
        r = TXT_L2_FIRST;
      else if (p >= TXT_L2_LAST)
        r = 7'h00;
      else
        r = p + 7'h01;
    end
    else
    begin
      if (p == TXT_L2_FIRST)
        r = TXT_L1_LAST;
      else if (p == 7'h00)
        r = TXT_L2_LAST;
      else
        r = p - 7'h01;
    end
    return r;
  endfunction : step_ptr

  wire [7:0] ib = xfer.byte_val;
  wire instr = xfer_vld && !xfer.rs && !busy;
  wire dwr = xfer_vld && xfer.rs;
  wire [7:0] cur_mem = glyph_sel ? gly_mem[ptr[5:0]] : txt_mem[ptr];

  always_ff @(posedge i_ref_clk)
  begin
    if (dwr)
    begin
      if (glyph_sel)
        gly_mem[ptr[5:0]] <= ib;
      else
        txt_mem[ptr] <= ib;
    end
  end

  // Pointer, memory select and mode bits
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ptr <= 7'h00;
      glyph_sel <= 1'b0;
      dir_inc <= 1'b1;
      two_line <= 1'b0;
      font_big <= 1'b0;
      bw8 <= 1'b1;
    end
    else if (instr && ib[B_DDR])
    begin
      ptr <= ib[6:0];
      glyph_sel <= 1'b0;
    end
    else if (instr && ib[B_CGR])
    begin
      ptr <= {1'b0, ib[5:0]};
      glyph_sel <= 1'b1;
    end
    else if (instr && ib[B_FSET])
    begin
      bw8 <= ib[B_DL];
      two_line <= ib[B_N];
      font_big <= ib[B_F];
    end
    else if (instr && ib[B_SHIFT] && !ib[B_SC])
      ptr <= step_ptr(ptr, ib[B_RL], glyph_sel, two_line);
    else if (instr && ib[B_ENTRY] && !ib[B_SC])
      dir_inc <= ib[B_ID];
    else if (dwr || rd_step)
      ptr <= step_ptr(ptr, dir_inc, glyph_sel, two_line);
  end

  // Read latch refills after address set, cursor shift and each read
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      rd_latch <= 8'h00;
      rd_fill <= 1'b0;
    end
    else
    begin
      // Refill one cycle after a read step so the latch holds the next byte
      rd_fill <= rd_step;
      if (instr && (ib[B_DDR] || ib[B_CGR] || (ib[B_SHIFT] && !ib[B_SC])))
        rd_latch <= 8'h00;
      else if (busy_cnt == 1 || rd_fill)
        rd_latch <= cur_mem;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      busy <= 1'b0;
      busy_cnt <= '0;
    end
    else if (xfer_vld && !busy)
    begin
      busy <= 1'b1;
      busy_cnt <= ($clog2(BUSY_CYC+1))'(BUSY_CYC);
    end
    else if (busy_cnt != 0)
      busy_cnt <= busy_cnt - 1'b1;
    else
      busy <= 1'b0;
  end

  // Parallel read path: status or data, nibble by nibble in four-bit mode
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_data <= 8'h00;
      o_data_oe <= 8'h00;
    end
    else
    begin
      logic [7:0] rv;
      rv = ctl_s[1] ? rd_latch : {busy, ptr};
      if ((if_mode == IF_PAR) && ctl_s[0] && ctl_s[2])
      begin
        o_data <= (bw8 || !nib_phase) ? rv : {rv[3:0], 4'h0};
        o_data_oe <= bw8 ? 8'hFF : 8'hF0;
      end
      else
        o_data_oe <= 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_busy_indicator <= 1'b0;
      o_address_pointer <= 7'h00;
      o_glyph_sel <= 1'b0;
      o_two_line <= 1'b0;
      o_duty <= DM_8;
      o_bus_width_bit <= 1'b1;
      o_if_mode <= IF_PAR;
    end
    else
    begin
      o_busy_indicator <= busy;
      o_address_pointer <= ptr;
      o_glyph_sel <= glyph_sel;
      o_two_line <= two_line;
      o_duty <= two_line ? DM_16 : (font_big ? DM_11 : DM_8);
      o_bus_width_bit <= bw8;
      o_if_mode <= if_mode;
    end
  end
endmodule : clhp_port

//--- verification/clhp_port_chk.sv
`timescale 1ns/1ps
module clhp_port_chk
  import clhp_pkg::*;
(
  input wire logic i_ref_clk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_interface_strap_hi, // Strap
  input wire logic i_interface_strap_lo, // Strap
  input wire logic i_enable, // Strobe
  input wire logic i_register_select, // Select
  input wire logic i_read_write, // Direction
  input wire logic [7:0] i_data, // Lines in
  input wire logic [7:0] o_data, // Lines out
  input wire logic [7:0] o_data_oe, // Drive enable
  input wire logic o_busy_indicator, // Busy
  input wire logic [6:0] o_address_pointer, // Pointer
  input wire logic o_glyph_sel, // Glyph select
  input wire logic o_two_line, // Line count
  input wire logic [1:0] o_duty, // Duty
  input wire logic o_bus_width_bit, // Width
  input wire logic [1:0] o_if_mode // Interface
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  duty_map_a: assert property (o_two_line == (o_duty == DM_16))
    else $error("duty and line count disagree");
  duty_cause_a: assert property ($changed(o_duty) |-> ##[0:2] o_busy_indicator)
    else $error("duty changed without instruction");
  sel_cause_a: assert property ($changed(o_glyph_sel) |-> ##[0:2] o_busy_indicator)
    else $error("memory select changed without instruction");
  ptr_step_a: assert property ($changed(o_address_pointer) |->
    (o_address_pointer - $past(o_address_pointer)) inside {7'h01, 7'h7F}
    or ##[0:2] o_busy_indicator) else $error("pointer jumped");
  busy_hold_a: assert property ($rose(o_busy_indicator) |=> o_busy_indicator [*8])
    else $error("busy pulse too short");
  oe_par_a: assert property (o_if_mode != IF_PAR |-> o_data_oe == 8'h00)
    else $error("lines driven in serial mode");
  oe_width_a: assert property (o_data_oe != 8'h00 |->
    o_data_oe == (o_bus_width_bit ? 8'hFF : 8'hF0)) else $error("wrong lines driven");
  oe_write_a: assert property ((!i_read_write) [*5] |-> o_data_oe == 8'h00)
    else $error("lines driven during write");
  oe_read_a: assert property ((i_enable && i_read_write && o_if_mode == IF_PAR) [*6]
    |-> o_data_oe != 8'h00) else $error("read not answered");
  if_spi_a: assert property (i_interface_strap_hi [*6] |-> o_if_mode == IF_SPI)
    else $error("serial strap ignored");
  if_par_a: assert property ((!i_interface_strap_hi && !i_interface_strap_lo) [*6]
    |-> o_if_mode == IF_PAR) else $error("parallel strap ignored");
endmodule : clhp_port_chk
bind clhp_port clhp_port_chk u_clhp_port_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_interface_strap_hi(i_interface_strap_hi), .i_interface_strap_lo(i_interface_strap_lo),
  .i_enable(i_enable), .i_register_select(i_register_select), .i_read_write(i_read_write),
  .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe), .o_busy_indicator(o_busy_indicator),
  .o_address_pointer(o_address_pointer), .o_glyph_sel(o_glyph_sel), .o_two_line(o_two_line),
  .o_duty(o_duty), .o_bus_width_bit(o_bus_width_bit), .o_if_mode(o_if_mode));

//--- verification/clhp_host.sv
`timescale 1ns/1ps
module clhp_host (
  input wire logic i_ref_clk, // Clock
  input wire logic [7:0] i_bus, // Resolved data lines
  output logic o_enable, // Strobe
  output logic o_rs, // Register select
  output logic o_rw, // Read or write
  output logic [7:0] o_data // Lines driven by host
);
  initial {o_enable, o_rs, o_rw, o_data} = 11'h060;
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] wb,
                       output logic [7:0] rb);
    @(posedge i_ref_clk);
    o_rs <= rs;
    o_rw <= rw;
    o_data <= rw ? ~o_data : wb; // Released lines toggle so stale data cannot pass
    o_enable <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    rb = i_bus;
    o_enable <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask : pulse
  task automatic put(input logic rs, input logic rw, input logic nib, input logic [7:0] wb,
                     output logic [7:0] rb);
    logic [7:0] r;
    if (nib)
    begin
      pulse(rs, rw, {wb[7:4], 4'h0}, r);
      rb[7:4] = r[7:4];
      pulse(rs, rw, {wb[3:0], 4'h0}, r);
      rb[3:0] = r[7:4];
    end
    else
      pulse(rs, rw, wb, rb);
  endtask : put
  task automatic spi(input logic rs, input logic [7:0] wb);
    @(posedge i_ref_clk);
    o_rs <= rs;
    o_rw <= 1'b0;
    // Idle first: left-over parallel data must not fake a clock edge
    o_data <= 8'h60;
    repeat (6) @(posedge i_ref_clk);
    o_data <= 8'h40;
    repeat (6) @(posedge i_ref_clk);
    for (int i = 7; i >= 0; i--)
    begin
      o_data <= {wb[i], 7'h00};
      repeat (6) @(posedge i_ref_clk);
      o_data <= {wb[i], 7'h40};
      repeat (6) @(posedge i_ref_clk);
    end
    o_data <= 8'h60;
  endtask : spi
endmodule : clhp_host

//--- verification/char_lcd_host_command_port_test.sv
`timescale 1ns/1ps
module char_lcd_host_command_port_test;
  import clhp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic s_hi = 1'b0;
  logic s_lo = 1'b0;
  logic nib = 1'b0;
  logic en, rs, rw, busy, gsel, two, bw;
  logic [7:0] hd, od, oe, r, d, rnd;
  logic [6:0] ptr, a;
  logic [1:0] duty, ifm;
  int errors = 0;
  int checks_done = 0;
  wire logic [7:0] bus = (oe & od) | (~oe & hd);
  always #2 i_ref_clk = ~i_ref_clk;
  clhp_host u_clhp_host (.i_ref_clk(i_ref_clk), .i_bus(bus), .o_enable(en), .o_rs(rs),
    .o_rw(rw), .o_data(hd));
  clhp_port u_clhp_port (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_interface_strap_hi(s_hi), .i_interface_strap_lo(s_lo), .i_enable(en),
    .i_register_select(rs), .i_read_write(rw), .i_data(bus), .o_data(od), .o_data_oe(oe),
    .o_busy_indicator(busy), .o_address_pointer(ptr), .o_glyph_sel(gsel), .o_two_line(two),
    .o_duty(duty), .o_bus_width_bit(bw), .o_if_mode(ifm));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic ready;
    for (int n = 0; n < 1500; n++)
    begin
      u_clhp_host.put(1'b0, 1'b1, nib, 8'h00, r);
      if (r[7] === 1'b0)
        return;
    end
    chk("ready", 8'h00, 8'hFF);
    tally_and_finish();
  endtask : ready
  task automatic cmd(input logic [7:0] b);
    ready();
    u_clhp_host.put(1'b0, 1'b0, nib, b, r);
    tick(4);
  endtask : cmd
  task automatic wr_step(input logic [6:0] exp);
    rnd = lfsr(rnd);
    u_clhp_host.put(1'b1, 1'b0, nib, rnd, r);
    tick(4);
    chk("pointer", {1'b0, exp}, {1'b0, ptr});
  endtask : wr_step
  initial
  begin
    rnd = 8'h10;
    tick(5);
    i_sys_rst <= 1'b0;
    tick(6);
    chk("reset", 8'h80, {bw, ptr});
    chk("flags", 8'h00, {1'b0, busy, gsel, two, duty, ifm});
    cmd(8'h34);
    chk("duty", {6'h0, DM_11}, {6'h0, duty});
    cmd(8'h06);
    rnd = lfsr(rnd);
    a = {1'b0, rnd[5:0]};
    cmd({1'b1, a});
    u_clhp_host.put(1'b0, 1'b1, nib, 8'h00, r);
    chk("status", {1'b1, a}, r);
    chk("glyph", 8'h00, {7'h0, gsel});
    wr_step(a + 7'h01);
    d = rnd;
    cmd({1'b1, a});
    ready();
    u_clhp_host.put(1'b1, 1'b1, nib, 8'h00, r);
    tick(4);
    chk("readback", d, r);
    chk("pointer", {1'b0, a + 7'h01}, {1'b0, ptr});
    $display("text memory test done");
    rnd = lfsr(rnd);
    a = {2'h0, rnd[4:0]};
    cmd({2'h1, a[5:0]});
    chk("glyph", {1'b1, a}, {gsel, ptr});
    wr_step(a + 7'h01);
    cmd(8'h04);
    wr_step(a);
    cmd(8'h28);
    chk("mode", 8'h03, {5'h0, bw, duty});
    nib = 1'b1;
    wr_step({1'b0, a[5:0] - 6'h01});
    ready();
    rnd = lfsr(rnd);
    a = {1'b1, 1'b0, rnd[4:0]};
    u_clhp_host.pulse(1'b0, 1'b0, {4'h8 | a[6:4], 4'h0}, r);
    tick(4);
    chk("busy first", 8'h00, {7'h0, busy});
    u_clhp_host.pulse(1'b0, 1'b0, {a[3:0], 4'h0}, r);
    tick(4);
    chk("busy second", {1'b1, a}, {busy, ptr});
    $display("nibble test done");
    cmd(8'h38);
    nib = 1'b0;
    ready();
    @(posedge i_ref_clk) s_hi <= 1'b1;
    tick(8);
    chk("spi mode", {6'h0, IF_SPI}, {6'h0, ifm});
    u_clhp_host.spi(1'b0, 8'h85);
    tick(8);
    chk("spi addr", 8'h05, {1'b0, ptr});
    u_clhp_host.spi(1'b1, 8'h3C);
    tick(8);
    chk("spi data", 8'h04, {1'b0, ptr});
    @(posedge i_ref_clk) s_hi <= 1'b0;
    s_lo <= 1'b1;
    tick(8);
    chk("i2c mode", {6'h0, IF_I2C}, {6'h0, ifm});
    $display("strap test done");
    tally_and_finish();
  end
endmodule : char_lcd_host_command_port_test
